// ---- common/cod_pkg.sv ----
/*
  constants, opcodes and types for the opcode decode tail block.
  assumes a single core clock (cpu bus clock) and an active-low async reset.
*/
//
// Summary of operation
// - single-byte opcode 35 loads the stack pointer with index a minus one in 3 cycles.
// - prefixed opcode 18 35 loads the stack pointer with index b minus one in 4 cycles.
// - the wait opcode 3e spends 12 cycles from the opcode fetch stacking registers.
// - after stacking the cpu idles a whole number n of cycles until an interrupt is recognized.
// - after the wait two vector fetch cycles follow, for 14 plus n cycles in total.
// - a direct page address is the operand byte with an upper byte of zero.
// - an index offset byte is unsigned 0 to 255 and is added to the index register.
// - an extended address is built from a high operand byte and a low operand byte.
// - a 16-bit immediate is built from a high operand byte and a low operand byte.
// - a bit mask byte marks with each set bit a bit position that is acted on.
// - a branch offset byte is sign extended, giving -128 to +127.
// - the branch offset is added to the address of the byte after the offset byte.
// - prefix byte 18 selects a second opcode page acting on index b.

package cod_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_PAGE_B       = 8'h18;
  localparam logic [7:0] OP_COPY_TO_SP   = 8'h35;
  localparam logic [7:0] OP_WAIT_FOR_IRQ = 8'h3e;

  // ==========================================================
  // cycle counts
  localparam logic [3:0] CYC_COPY_A  = 4'h3;
  localparam logic [3:0] CYC_COPY_B  = 4'h4;
  localparam logic [3:0] CYC_STACK   = 4'hc;
  localparam logic [3:0] CYC_VECTOR  = 4'h2;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_STACK_PTR = 16'h0000;
  localparam logic [15:0] RST_WORD      = 16'h0000;

  // ==========================================================
  // addressing mode of an operand request
  typedef enum logic [2:0] {
    COD_MODE_DIRECT,
    COD_MODE_INDEXED,
    COD_MODE_EXTENDED,
    COD_MODE_IMM16,
    COD_MODE_BRANCH
  } cod_mode_t;

  // execution sequencer states
  typedef enum logic [2:0] {
    COD_IDLE,
    COD_COPY,
    COD_STACKING,
    COD_WAITING,
    COD_VECTOR
  } cod_state_t;

endpackage

// ---- common/cod_opnd_if.sv ----
/*
  interface carrying operand bytes to the operand former and its result back.
  assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface cod_opnd_if;
  import cod_pkg::*;
  logic             req;
  cod_mode_t        mode;
  logic [7:0]       byte_high;
  logic [7:0]       byte_low;
  logic [15:0]      index_val;
  logic [15:0]      next_pc;
  logic [15:0]      result;
  logic             done;

  modport requester (output req, output mode, output byte_high, output byte_low,
                     output index_val, output next_pc, input result, input done);
  modport former    (input req, input mode, input byte_high, input byte_low,
                     input index_val, input next_pc, output result, output done);
endinterface

`default_nettype wire

// ---- design/cod_operand_former.sv ----
/*
  forms effective addresses and 16-bit values from instruction operand bytes.
  assumes the requester holds its inputs during the request cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module cod_operand_former
(
  input  wire logic     core_clk,
  input  wire logic     rstn,
  cod_opnd_if.former    opnd
);
  import cod_pkg::*;

  // ==========================================================
  // sign extension of a branch displacement
  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction

  // ==========================================================
  // registered operand result
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      opnd.result <= RST_WORD;
      opnd.done   <= 1'b0;
    end
    else
    begin
      opnd.done <= opnd.req;
      if (opnd.req)
      begin
        unique case (opnd.mode)
          COD_MODE_DIRECT:   opnd.result <= {8'h00, opnd.byte_low};
          COD_MODE_INDEXED:  opnd.result <= opnd.index_val + {8'h00, opnd.byte_low};
          COD_MODE_EXTENDED: opnd.result <= {opnd.byte_high, opnd.byte_low};
          COD_MODE_IMM16:    opnd.result <= {opnd.byte_high, opnd.byte_low};
          COD_MODE_BRANCH:   opnd.result <= opnd.next_pc + sext8(opnd.byte_low);
          default:           opnd.result <= RST_WORD;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ---- design/cod_decode_tail.sv ----
/*
  decode and execution timing for index-to-stack copies, the wait-for-interrupt
  instruction and operand byte forms.
  assumes opcode bytes arrive one per cycle with a valid strobe from same-clock fetch
  logic, and that irq_masked carries the mask state from the core, applied here to irq_request.
*/
`timescale 1ns/1ps
`default_nettype none

module cod_decode_tail
(
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                op_valid,
  input  wire logic [7:0]          op_byte,
  input  wire logic [15:0]         index_reg_a,
  input  wire logic [15:0]         index_reg_b,
  input  wire logic                irq_request,
  input  wire logic                irq_masked,
  input  wire logic                opnd_req,
  input  wire cod_pkg::cod_mode_t  opnd_mode,
  input  wire logic [7:0]          opnd_byte_high,
  input  wire logic [7:0]          opnd_byte_low,
  input  wire logic                opnd_use_b,
  input  wire logic [15:0]         opnd_next_pc,
  input  wire logic [7:0]          bit_mask_byte,
  input  wire logic [7:0]          bit_data_in,
  input  wire logic                bit_set_mode,
  output logic [15:0]              stack_ptr,
  output logic                     busy,
  output logic                     stacking,
  output logic                     wait_idle,
  output logic                     vector_fetch,
  output logic                     instr_done,
  output logic [15:0]              opnd_result,
  output logic                     opnd_done,
  output logic [7:0]               bit_data_out
);
  import cod_pkg::*;

  cod_state_t  state;
  logic [3:0]  cyc_cnt;
  logic [3:0]  cyc_target;
  logic        page_b;
  logic        sel_b;
  logic [15:0] sp_source;
  logic        exec_copy;

  cod_opnd_if  opnd ();

  // ==========================================================
  // page select prefix latch
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      page_b <= 1'b0;
    else if (op_valid && state == COD_IDLE)
      page_b <= (op_byte == OP_PAGE_B) && !page_b;
  end

  // ==========================================================
  // copy decode: a copy opcode seen while idle
  assign exec_copy = op_valid && (state == COD_IDLE) && (op_byte == OP_COPY_TO_SP);

  // ==========================================================
  // sequencer state and cycle counter
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state      <= COD_IDLE;
      cyc_cnt    <= 4'h0;
      cyc_target <= 4'h0;
      sel_b      <= 1'b0;
    end
    else
    begin
      unique case (state)
        COD_IDLE:
        begin
          cyc_cnt <= 4'h1;
          if (exec_copy)
          begin
            state      <= COD_COPY;
            sel_b      <= page_b;
            // the prefix fetch already used one cycle, so count from 2
            cyc_cnt    <= page_b ? 4'h2 : 4'h1;
            cyc_target <= page_b ? CYC_COPY_B : CYC_COPY_A;
          end
          else if (op_valid && !page_b && op_byte == OP_WAIT_FOR_IRQ)
          begin
            state      <= COD_STACKING;
            cyc_target <= CYC_STACK;
          end
        end
        COD_COPY:
        begin
          cyc_cnt <= cyc_cnt + 4'h1;
          if (cyc_cnt + 4'h1 == cyc_target)
            state <= COD_IDLE;
        end
        COD_STACKING:
        begin
          cyc_cnt <= cyc_cnt + 4'h1;
          if (cyc_cnt + 4'h1 == cyc_target)
            state <= COD_WAITING;
        end
        COD_WAITING:
        begin
          cyc_cnt <= 4'h0;
          if (irq_request && !irq_masked)
            state <= COD_VECTOR;
        end
        COD_VECTOR:
        begin
          cyc_cnt <= cyc_cnt + 4'h1;
          if (cyc_cnt + 4'h1 == CYC_VECTOR)
            state <= COD_IDLE;
        end
        default:
          state <= COD_IDLE;
      endcase
    end
  end

  // ==========================================================
  // stack pointer load: index minus one on the last copy cycle
  assign sp_source = sel_b ? index_reg_b : index_reg_a;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      stack_ptr <= RST_STACK_PTR;
    else if (state == COD_COPY && cyc_cnt + 4'h1 == cyc_target)
      stack_ptr <= sp_source - 16'h0001;
  end

  // ==========================================================
  // completion pulse and phase indications
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      instr_done <= 1'b0;
    else
      instr_done <= ((state == COD_COPY) && (cyc_cnt + 4'h1 == cyc_target))
                 || ((state == COD_VECTOR) && (cyc_cnt + 4'h1 == CYC_VECTOR));
  end

  assign busy         = (state != COD_IDLE);
  assign stacking     = (state == COD_STACKING);
  assign wait_idle    = (state == COD_WAITING);
  assign vector_fetch = (state == COD_VECTOR);

  // ==========================================================
  // bit manipulation: set bits in mask are acted on
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      bit_data_out <= 8'h00;
    else if (bit_set_mode)
      bit_data_out <= bit_data_in | bit_mask_byte;
    else
      bit_data_out <= bit_data_in & ~bit_mask_byte;
  end

  // ==========================================================
  // operand former hookup
  assign opnd.req       = opnd_req;
  assign opnd.mode      = opnd_mode;
  assign opnd.byte_high = opnd_byte_high;
  assign opnd.byte_low  = opnd_byte_low;
  assign opnd.index_val = opnd_use_b ? index_reg_b : index_reg_a;
  assign opnd.next_pc   = opnd_next_pc;
  assign opnd_result    = opnd.result;
  assign opnd_done      = opnd.done;

  cod_operand_former u_former
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .opnd     (opnd.former)
  );

endmodule

`default_nettype wire

// ---- sim/cod_fetch_model.sv ----
/*
  program memory model: offers up to three opcode bytes, one per cycle, to the decoder.
  assumes the decoder takes a byte at a rising edge with op_valid high and busy low.
*/
`timescale 1ns/1ps
`default_nettype none
module cod_fetch_model
(
  input  wire logic        core_clk,
  input  wire logic        busy,
  input  wire logic        go,
  input  wire logic [23:0] prog,
  input  wire logic [1:0]  len,
  output logic             op_valid,
  output logic [7:0]       op_byte
);
  // ==========================================================
  // byte stream
  logic [1:0] left = 2'h0;
  logic [1:0] pos  = 2'h0;
  initial op_valid = 1'b0;
  initial op_byte  = 8'h00;
  // count off bytes the decoder took
  always @(posedge core_clk)
    if (go) {left, pos} <= {len, 2'h0};
    else if (op_valid && !busy) {left, pos} <= {left - 2'h1, pos + 2'h1};
  // offer next byte; a released bus shows the inverse of its last value
  always @(negedge core_clk)
    if (left != 2'h0 && !busy) {op_valid, op_byte} = {1'b1, prog[8 * (2 - pos) +: 8]};
    else {op_valid, op_byte} = {1'b0, ~op_byte};
endmodule
`default_nettype wire

// ---- sim/cod_decode_tail_monitor.sv ----
/*
  port checker for the decode tail; bound to every instance of it.
  assumes one clock domain and the async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cod_decode_tail_chk
(
  input wire logic               core_clk,
  input wire logic               rstn,
  input wire logic               op_valid,
  input wire logic [7:0]         op_byte,
  input wire logic [15:0]        index_reg_a,
  input wire logic [15:0]        index_reg_b,
  input wire logic               irq_request,
  input wire logic               irq_masked,
  input wire logic               opnd_req,
  input wire cod_pkg::cod_mode_t opnd_mode,
  input wire logic [7:0]         opnd_byte_high,
  input wire logic [7:0]         opnd_byte_low,
  input wire logic               opnd_use_b,
  input wire logic [15:0]        opnd_next_pc,
  input wire logic [7:0]         bit_mask_byte,
  input wire logic [7:0]         bit_data_in,
  input wire logic               bit_set_mode,
  input wire logic [15:0]        stack_ptr,
  input wire logic               busy,
  input wire logic               stacking,
  input wire logic               wait_idle,
  input wire logic               vector_fetch,
  input wire logic               instr_done,
  input wire logic [15:0]        opnd_result,
  input wire logic               opnd_done,
  input wire logic [7:0]         bit_data_out
);
  import cod_pkg::*;
  // ==========================================================
  // helpers
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic pg;
  wire logic take = op_valid && !busy;
  wire logic [15:0] disp = {{8{opnd_byte_low[7]}}, opnd_byte_low};
  wire logic [15:0] ixv = opnd_use_b ? index_reg_b : index_reg_a;
  wire logic [7:0] bexp = bit_set_mode ? bit_data_in | bit_mask_byte : bit_data_in & ~bit_mask_byte;
  // page b armed by a taken prefix byte
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn) pg <= 1'b0;
    else if (take) pg <= op_byte == OP_PAGE_B && !pg;
  // ==========================================================
  // properties
  property p_copy_a; take && op_byte == OP_COPY_TO_SP && !pg |-> ##3 instr_done && stack_ptr == index_reg_a - 16'h1;
  endproperty
  a_copy_a: assert property (p_copy_a) else $error("copy a wrong");
  property p_copy_b; take && op_byte == OP_COPY_TO_SP && pg |-> ##3 instr_done && stack_ptr == index_reg_b - 16'h1;
  endproperty
  a_copy_b: assert property (p_copy_b) else $error("copy b wrong");
  property p_stack; take && op_byte == OP_WAIT_FOR_IRQ && !pg |=> stacking[*8] ##1 stacking[*3] ##1 wait_idle;
  endproperty
  a_stack: assert property (p_stack) else $error("stacking span wrong");
  property p_page_wait; take && op_byte == OP_WAIT_FOR_IRQ && pg |=> !stacking; endproperty
  a_page_wait: assert property (p_page_wait) else $error("paged wait not ignored");
  property p_idle; wait_idle && !(irq_request && !irq_masked) |=> wait_idle; endproperty
  a_idle: assert property (p_idle) else $error("wait left early");
  property p_vec; wait_idle && irq_request && !irq_masked |=> vector_fetch[*2] ##1 !busy && instr_done; endproperty
  a_vec: assert property (p_vec) else $error("vector fetch wrong");
  property p_dir; opnd_req && opnd_mode == COD_MODE_DIRECT |=> opnd_done && opnd_result == {8'h00, $past(opnd_byte_low)};
  endproperty
  a_dir: assert property (p_dir) else $error("direct wrong");
  property p_idx; opnd_req && opnd_mode == COD_MODE_INDEXED |=> opnd_result == $past(ixv) + {8'h00, $past(opnd_byte_low)};
  endproperty
  a_idx: assert property (p_idx) else $error("indexed wrong");
  property p_w16; opnd_req && opnd_mode inside {COD_MODE_EXTENDED, COD_MODE_IMM16}
    |=> opnd_result == {$past(opnd_byte_high), $past(opnd_byte_low)}; endproperty
  a_w16: assert property (p_w16) else $error("16-bit operand wrong");
  property p_br; opnd_req && opnd_mode == COD_MODE_BRANCH |=> opnd_result == $past(opnd_next_pc) + $past(disp);
  endproperty
  a_br: assert property (p_br) else $error("branch wrong");
  property p_bit; bit_mask_byte != 8'h00 |=> bit_data_out == $past(bexp); endproperty
  a_bit: assert property (p_bit) else $error("bit op wrong");
  // main scenarios
  c_wake: cover property (wait_idle ##1 vector_fetch);
  c_copy_b: cover property (take && pg && op_byte == OP_COPY_TO_SP);
  c_br: cover property (opnd_req && opnd_mode == COD_MODE_BRANCH);
endmodule
bind cod_decode_tail cod_decode_tail_chk cod_decode_tail_chk_inst (.*);
`default_nettype wire

// ---- sim/testbench.sv ----
/*
  self-checking bench for the decode tail with a program memory model.
  assumes the checker is bound in from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cod_pkg::*;
  // ==========================================================
  // stimulus and wiring
  logic core_clk, rstn, go, op_valid, irq_request, irq_masked, opnd_req, opnd_use_b, bit_set_mode;
  logic busy, stacking, wait_idle, vector_fetch, instr_done, opnd_done;
  logic [1:0] len;
  logic [23:0] prog;
  logic [7:0] op_byte, opnd_byte_high, opnd_byte_low, bit_mask_byte, bit_data_in, bit_data_out;
  logic [15:0] index_reg_a, index_reg_b, opnd_next_pc, stack_ptr, opnd_result;
  cod_mode_t opnd_mode;
  int n_fail = 0;
  int n_tests = 0;
  cod_decode_tail cod_decode_tail_inst (.*);
  cod_fetch_model cod_fetch_model_inst (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic start(input logic [23:0] p, input logic [1:0] n);
    @(negedge core_clk) {go, prog, len} = {1'b1, p, n};
    @(negedge core_clk) go = 1'b0;
  endtask
  task automatic wait_done;
    for (int i = 0; i < 30 && instr_done !== 1'b1; i++) @(negedge core_clk);
    chk(instr_done, 1'b1);
    @(negedge core_clk);
  endtask
  // back-to-back copies, index a at zero wraps
  task automatic t_copy;
    {index_reg_a, index_reg_b} = {16'h0000, 16'h8000};
    start({OP_COPY_TO_SP, OP_PAGE_B, OP_COPY_TO_SP}, 2'h3);
    wait_done();
    chk(stack_ptr, 16'hffff);
    wait_done();
    chk(stack_ptr, 16'h7fff);
  endtask
  // wait opcode after the prefix is ignored
  task automatic t_prefix;
    start({OP_PAGE_B, OP_WAIT_FOR_IRQ, 8'h00}, 2'h2);
    repeat (4) @(negedge core_clk);
    chk({stacking, busy}, 16'h0);
  endtask
  // stacking span, masked request ignored, two vector cycles
  task automatic t_wait;
    int n;
    {irq_request, irq_masked, n} = {2'b11, 32'd1};
    start({OP_WAIT_FOR_IRQ, 16'h0000}, 2'h1);
    for (int i = 0; i < 30 && wait_idle !== 1'b1; i++) @(negedge core_clk) n += stacking;
    chk(n, 32'(CYC_STACK));
    repeat (6) @(negedge core_clk);
    chk(wait_idle, 1'b1);
    {irq_masked, n} = 0;
    for (int i = 0; i < 10 && instr_done !== 1'b1; i++) @(negedge core_clk) n += vector_fetch;
    chk(n, 32'(CYC_VECTOR));
    irq_request = 1'b0;
  endtask
  task automatic opnd(input cod_mode_t m, input logic [7:0] hi, lo, input logic b, input logic [15:0] exp);
    @(negedge core_clk) opnd_mode = m;
    {opnd_req, opnd_byte_high, opnd_byte_low, opnd_use_b} = {1'b1, hi, lo, b};
    @(negedge core_clk) chk({opnd_done, opnd_result}, {1'b1, exp});
    opnd_req = 1'b0;
  endtask
  // every operand form with boundary bytes
  task automatic t_opnd;
    {index_reg_a, opnd_next_pc} = {16'hff01, 16'h1000};
    opnd(COD_MODE_DIRECT, 8'h12, 8'hff, 1'b0, 16'h00ff);
    opnd(COD_MODE_INDEXED, 8'h00, 8'hff, 1'b0, 16'h0000);
    opnd(COD_MODE_INDEXED, 8'h00, 8'h80, 1'b1, 16'h8080);
    opnd(COD_MODE_EXTENDED, 8'hab, 8'hcd, 1'b0, 16'habcd);
    opnd(COD_MODE_IMM16, 8'h01, 8'hfe, 1'b0, 16'h01fe);
    opnd(COD_MODE_BRANCH, 8'h00, 8'h80, 1'b0, 16'h0f80);
    opnd(COD_MODE_BRANCH, 8'h00, 8'h7f, 1'b0, 16'h107f);
  endtask
  // set then clear under one mask
  task automatic t_bits;
    @(negedge core_clk) {bit_mask_byte, bit_data_in, bit_set_mode} = {8'h0f, 8'ha5, 1'b1};
    @(negedge core_clk) chk(bit_data_out, 16'h00af);
    bit_set_mode = 1'b0;
    @(negedge core_clk) chk(bit_data_out, 16'h00a0);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {rstn, go, prog, len, irq_request, irq_masked, opnd_req, opnd_use_b, bit_set_mode} = 0;
    {index_reg_a, index_reg_b, opnd_next_pc, opnd_byte_high, opnd_byte_low, bit_mask_byte, bit_data_in} = 0;
    opnd_mode = COD_MODE_DIRECT;
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    t_copy();
    t_prefix();
    t_wait();
    t_opnd();
    t_bits();
    tally_and_finish();
  end
  // watchdog
  initial
  begin
    #100us;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
